// ---- asf_pkg.sv ----
// package: shared constants for the async serial frame core
package asf_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ASF_REG_CTRL   = 4'h0; // enables and format
  localparam logic [3:0] ASF_REG_BAUD   = 4'h1; // baud divisor
  localparam logic [3:0] ASF_REG_TXDATA = 4'h2; // transmit character
  localparam logic [3:0] ASF_REG_RXDATA = 4'h3; // receive character
  localparam logic [3:0] ASF_REG_STAT   = 4'h4; // live status
  localparam logic [3:0] ASF_REG_IRQ    = 4'h5; // sticky event bits
  localparam logic [3:0] ASF_REG_IRQEN  = 4'h6; // event enables
  localparam logic [3:0] ASF_REG_IRQCLR = 4'h7; // write one to clear
  // control register field positions
  localparam int ASF_CTRL_TXEN   = 0; // transmitter enable
  localparam int ASF_CTRL_RXEN   = 1; // receiver enable
  localparam int ASF_CTRL_NINE   = 2; // nine data bits
  localparam int ASF_CTRL_ADDEN  = 3; // address detection
  localparam int ASF_CTRL_BRG16  = 4; // sixteen bit divider
  localparam int ASF_CTRL_BREAK  = 5; // send break next
  localparam int ASF_CTRL_TX9    = 6; // tx_ninth_bit
  // sticky event bit positions
  localparam int ASF_EV_TXDONE = 0; // frame sent
  localparam int ASF_EV_RXRDY  = 1; // character received
  localparam int ASF_EV_OVR    = 2; // overrun
  localparam int ASF_EV_FERR   = 3; // framing error
  localparam int ASF_EV_W      = 4; // number of events
  // reset values
  localparam logic [6:0]  ASF_CTRL_RST = 7'h00;
  localparam logic [15:0] ASF_BAUD_RST = 16'h0015;
  // frame figures
  localparam int ASF_BREAK_BITS = 13; // break length in bit times
  localparam int ASF_SYNC_FF    = 3;  // pin synchroniser depth
endpackage : asf_pkg

// ---- asf_baud_gen.sv ----
// baud tick generator: divides the system clock by divisor plus one
module asf_baud_gen #(
  parameter int W = 16                 // divisor width
) (
  input  wire logic         i_clk,     // system clock
  input  wire logic         i_rst_b,   // async reset, active low
  input  wire logic         i_restart, // realign the count
  input  wire logic         i_wide,    // use all W bits
  input  wire logic [W-1:0] i_div,     // divisor value
  output logic              o_tick     // one cycle pulse each period
);
  // elaboration check: the eight-bit mode needs at least eight bits
  if (W < 8) begin : g_w_check
    $error("asf_baud_gen: W below 8");
  end
  logic [W-1:0] count;                  // down counter
  wire  [W-1:0] eff_div = i_wide ? i_div : {{(W-8){1'b0}}, i_div[7:0]};
  wire          at_zero = (count == '0);
  // reload at zero so the period is eff_div + 1 cycles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
    end else if (i_restart || at_zero) begin
      count <= eff_div;
    end else begin
      count <= count - 1'b1;
    end
  end
  assign o_tick = at_zero && !i_restart;
endmodule : asf_baud_gen

// ---- asf_core.sv ----
// async serial frame core: transmitter, receiver, registers, interrupt
// How it works
// - idle transmit line rests at mark
// - one start, eight or nine data bits
// - start bit space, stop bit mark
// - each bit lasts one bit period
// - data bits least significant first
// - transmit and receive run independently, shared format
// - no hardware parity, ninth bit software
// - eight or sixteen bit baud divider
// - overrun when buffer full at arrival
// - bad stop bit flags framing error
// - nine bit address detection filters characters
// - break of thirteen bit times
// - enabled section drives its own pin
// - disabled section releases pin to GPIO
// - ninth bit is MSB, sent last
// - ninth bit one marks an address
//
// Our own choices: the address map and strobed register access.
module asf_core
  import asf_pkg::*;
#(
  parameter int OVS = 16                  // receive samples per bit
) (
  input  wire logic        i_clk,         // 40 MHz system clock
  input  wire logic        i_rst_b,       // async reset, active low
  input  wire logic [3:0]  i_addr,        // register index
  input  wire logic [15:0] i_wdata,       // write data
  input  wire logic        i_wr,          // write strobe
  input  wire logic        i_rd,          // read strobe
  output logic      [15:0] o_rdata,       // read data, cycle after read
  input  wire logic        i_serial_in_pin, // receive pin level
  output logic             o_serial_out_pin, // transmit pin level
  output logic             o_serial_out_oe,  // transmit pin driven
  output logic             o_rx_pin_owned,   // receive pin used by core
  output logic             o_irq          // level interrupt
);
  import asf_pkg::*;
  // elaboration check: the bit counters assume sixteen samples per bit
  if (OVS != 16) begin : g_ovs_check
    $error("asf_core: OVS must be 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [6:0]  ctrl;             // control bits
  logic [15:0] baud;             // divisor, per oversample tick
  logic [8:0]  tx_hold;          // one character output buffer
  logic        tx_hold_full;     // output buffer holds a character
  logic        break_req;        // break pending
  logic [8:0]  rx_buf;           // received character
  logic        rx_full;          // receive buffer occupied
  logic        rx_ferr_buf;      // framing error for buffered char
  logic [ASF_EV_W-1:0] irq_stat; // sticky events
  logic [ASF_EV_W-1:0] irq_en;   // event enables

  wire tx_en   = ctrl[ASF_CTRL_TXEN];
  wire rx_en   = ctrl[ASF_CTRL_RXEN];
  wire nine    = ctrl[ASF_CTRL_NINE];
  wire adden   = ctrl[ASF_CTRL_ADDEN];
  wire wr_ctrl = i_wr && (i_addr == ASF_REG_CTRL);
  wire wr_baud = i_wr && (i_addr == ASF_REG_BAUD);
  wire wr_tx   = i_wr && (i_addr == ASF_REG_TXDATA);
  wire rd_rx   = i_rd && (i_addr == ASF_REG_RXDATA);
  wire wr_ien  = i_wr && (i_addr == ASF_REG_IRQEN);
  wire wr_iclr = i_wr && (i_addr == ASF_REG_IRQCLR);

  ////////////////////////////////////////////////////////////////////////
  // oversample tick, shared by both paths
  logic os_tick; // one pulse per sixteenth of a bit
  asf_baud_gen #(.W(16)) asf_baud_gen_i (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_restart (wr_baud),
    .i_wide    (ctrl[ASF_CTRL_BRG16]),
    .i_div     (baud),
    .o_tick    (os_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  typedef enum logic [1:0] {ASF_TX_IDLE, ASF_TX_SHIFT} asf_tx_t;
  asf_tx_t     tx_state;   // transmit state
  logic [10:0] tx_shift;   // start, data, stop, shifted out lsb first
  logic [3:0]  tx_left;    // bits still to send
  logic [3:0]  tx_os;      // oversample count inside one bit
  logic        tx_line;    // line level
  logic        tx_busy_brk;// current frame is a break

  wire tx_bit_end = os_tick && (tx_os == 4'hf);
  wire tx_last    = tx_bit_end && (tx_left == 4'h1);
  wire tx_load    = (tx_state == ASF_TX_IDLE) && tx_en
                    && (tx_hold_full || break_req) && os_tick;
  // starting on a tick keeps the start bit a full sixteen ticks long
  // frame: stop, optional ninth bit, data, start; lsb leaves first
  wire [10:0] frame_9 = {1'b1, tx_hold[8], tx_hold[7:0], 1'b0};
  wire [10:0] frame_8 = {1'b1, 1'b1, tx_hold[7:0], 1'b0};

  // shift the frame one bit per sixteen ticks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state    <= ASF_TX_IDLE;
      tx_shift    <= '1;
      tx_left     <= 4'h0;
      tx_os       <= 4'h0;
      tx_line     <= 1'b1;
      tx_busy_brk <= 1'b0;
    end else begin
      case (tx_state)
        ASF_TX_IDLE: begin
          tx_line <= 1'b1;
          tx_os   <= 4'h0;
          if (tx_load) begin
            tx_state    <= ASF_TX_SHIFT;
            tx_busy_brk <= break_req;
            // break: 13 zero bits then one stop bit
            tx_shift    <= break_req ? 11'h000
                           : (nine ? frame_9 : frame_8);
            tx_left     <= break_req ? 4'(ASF_BREAK_BITS + 1)
                           : (nine ? 4'd11 : 4'd10);
            tx_line     <= 1'b0; // start bit space
          end
        end
        ASF_TX_SHIFT: begin
          if (os_tick) tx_os <= tx_os + 4'h1;
          if (tx_last) begin
            tx_state <= ASF_TX_IDLE;
            tx_line  <= 1'b1;
          end else if (tx_bit_end) begin
            // lsb first; break ends on a mark stop bit
            // a break fills with space so all 13 bits stay low
            tx_shift <= {!tx_busy_brk, tx_shift[10:1]};
            tx_left  <= tx_left - 4'h1;
            tx_line  <= (tx_busy_brk && tx_left == 4'h2) ? 1'b1
                        : tx_shift[1];
          end
        end
        default: tx_state <= ASF_TX_IDLE;
      endcase
    end
  end
  assign o_serial_out_pin = tx_line;
  assign o_serial_out_oe  = tx_en;

  ////////////////////////////////////////////////////////////////////////
  // receive pin synchroniser, three stages
  logic [ASF_SYNC_FF-1:0] rx_sync; // [0] first stage, read only by [1]
  logic                   rx_lvl;  // filtered line level
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_sync <= '1;
      rx_lvl  <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], i_serial_in_pin};
      if (rx_sync[1] == rx_sync[2]) rx_lvl <= rx_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  typedef enum logic [1:0] {ASF_RX_IDLE, ASF_RX_START, ASF_RX_DATA,
                            ASF_RX_STOP} asf_rx_t;
  asf_rx_t    rx_state; // receive state
  logic [3:0] rx_os;    // oversample count
  logic [3:0] rx_cnt;   // data bits taken
  logic [8:0] rx_sh;    // incoming data, fills from the top
  wire        rx_mid  = os_tick && (rx_os == 4'h7);
  wire [3:0]  rx_nbit = nine ? 4'd9 : 4'd8;
  wire [8:0]  rx_char = nine ? rx_sh : {1'b0, rx_sh[8:1]};
  // address filter: drop data characters
  wire        rx_keep = !(nine && adden) || rx_char[8];
  wire        rx_done = (rx_state == ASF_RX_STOP) && rx_mid;
  wire        rx_push = rx_done && rx_keep;
  wire        rx_ovr  = rx_push && rx_full && !rd_rx;

  // sample each bit mid-period after a falling edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state <= ASF_RX_IDLE;
      rx_os    <= 4'h0;
      rx_cnt   <= 4'h0;
      rx_sh    <= '0;
    end else if (!rx_en) begin
      rx_state <= ASF_RX_IDLE;
    end else begin
      if (os_tick) rx_os <= rx_os + 4'h1;
      case (rx_state)
        ASF_RX_IDLE: begin
          rx_os <= 4'h0;
          if (!rx_lvl) rx_state <= ASF_RX_START;
        end
        ASF_RX_START: if (rx_mid) begin
          // false start if the line is back at mark
          rx_state <= rx_lvl ? ASF_RX_IDLE : ASF_RX_DATA;
          rx_cnt   <= 4'h0;
        end
        ASF_RX_DATA: if (rx_mid) begin
          rx_sh  <= {rx_lvl, rx_sh[8:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt + 4'h1 == rx_nbit) rx_state <= ASF_RX_STOP;
        end
        ASF_RX_STOP: if (rx_mid) rx_state <= ASF_RX_IDLE;
        default: rx_state <= ASF_RX_IDLE;
      endcase
    end
  end

  // buffer: an overrun keeps the old character, new one is lost
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_buf      <= '0;
      rx_full     <= 1'b0;
      rx_ferr_buf <= 1'b0;
    end else if (rx_push && !rx_ovr) begin
      rx_buf      <= rx_char;
      rx_full     <= 1'b1;
      rx_ferr_buf <= !rx_lvl;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end
  assign o_rx_pin_owned = rx_en;

  ////////////////////////////////////////////////////////////////////////
  // control registers and output buffer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl         <= ASF_CTRL_RST;
      baud         <= ASF_BAUD_RST;
      tx_hold      <= '0;
      tx_hold_full <= 1'b0;
      break_req    <= 1'b0;
      irq_en       <= '0;
    end else begin
      if (wr_ctrl) ctrl <= i_wdata[6:0] & 7'h5f; // break bit self-clears
      if (wr_baud) baud <= i_wdata;
      if (wr_ien)  irq_en <= i_wdata[ASF_EV_W-1:0];
      if (wr_ctrl && i_wdata[ASF_CTRL_BREAK]) break_req <= 1'b1;
      else if (tx_load) break_req <= 1'b0;
      // tx_ninth_bit travels with the character, no parity
      if (wr_tx && !tx_hold_full) begin
        tx_hold      <= {ctrl[ASF_CTRL_TX9], i_wdata[7:0]};
        tx_hold_full <= 1'b1;
      end else if (tx_load && !break_req) begin
        tx_hold_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky interrupt status; a set beats a clear in the same cycle
  wire [ASF_EV_W-1:0] ev_set = {rx_push && !rx_ovr && !rx_lvl,
                                rx_ovr, rx_push && !rx_ovr, tx_last};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_iclr ? i_wdata[ASF_EV_W-1:0]
                                        : {ASF_EV_W{1'b0}})) | ev_set;
    end
  end
  assign o_irq = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  wire [15:0] stat_word = {10'h000, rx_state != ASF_RX_IDLE,
                           rx_ferr_buf, rx_full, tx_state == ASF_TX_IDLE,
                           tx_hold_full, break_req};
  logic [15:0] next_rdata; // selected read value
  always_comb begin
    case (i_addr)
      ASF_REG_CTRL:   next_rdata = {9'h000, ctrl};
      ASF_REG_BAUD:   next_rdata = baud;
      ASF_REG_RXDATA: next_rdata = {7'h00, rx_buf};
      ASF_REG_STAT:   next_rdata = stat_word;
      ASF_REG_IRQ:    next_rdata = {12'h000, irq_stat};
      ASF_REG_IRQEN:  next_rdata = {12'h000, irq_en};
      default:        next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_rdata <= 16'h0000;
    else          o_rdata <= i_rd ? next_rdata : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  idle_mark_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (tx_state == ASF_TX_IDLE) |-> o_serial_out_pin)
    else $error("line not at mark while idle");
  start_space_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    tx_load |=> !o_serial_out_pin)
    else $error("start bit not space");
  bit_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (tx_state == ASF_TX_SHIFT && !tx_bit_end) |=> $stable(tx_line))
    else $error("line moved inside a bit");
  stop_mark_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    tx_last |=> o_serial_out_pin)
    else $error("stop not mark");
  ovr_keep_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    rx_ovr |=> irq_stat[ASF_EV_OVR] && $stable(rx_buf))
    else $error("overrun lost or buffer overwritten");
  ferr_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (rx_push && !rx_ovr && !rx_lvl) |=> rx_ferr_buf)
    else $error("framing error missed");
  // a read in the same cycle may empty the buffer legally
  addr_drop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (rx_done && nine && adden && !rx_char[8] && !rd_rx)
    |=> $stable(rx_full))
    else $error("data kept in address mode");
  pin_release_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !tx_en |-> !o_serial_out_oe)
    else $error("pin driven while disabled");
endmodule : asf_core

// ---- asf_remote_node.sv ----
// far-side serial node model: sends and checks frames on the pins
module asf_remote_node #(
  parameter int BITC = 32              // clock cycles per bit
) (
  input  wire logic i_clk,             // system clock
  input  wire logic i_line,            // level of the core transmit pin
  output logic      o_line             // level fed to the core receive pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_line = 1'b1;               // line rests at mark
  //////////////////////////////////////////////////////////////////////
  // send one frame; a stop level of 0 makes a deliberate framing fault
  task automatic send(input int n, input logic [8:0] d, input logic stp);
    o_line <= 1'b0;                    // start bit at space
    repeat (BITC) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      o_line <= d[k];
      repeat (BITC) @(posedge i_clk);
    end
    o_line <= stp;                     // stop bit
    repeat (BITC) @(posedge i_clk);
    o_line <= 1'b1;                    // back to mark between characters
  endtask : send
  //////////////////////////////////////////////////////////////////////
  // catch one frame, sampling mid-bit; unknowns come back on a stall
  task automatic recv(input int n, output logic [8:0] d, output logic stp);
    int t;
    d = 'x;
    stp = 1'bx;
    t = 0;
    while (i_line !== 1'b0 && t < 4000) begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 4000) return;             // no start bit: leave unknowns
    repeat (BITC / 2) @(posedge i_clk);
    if (i_line !== 1'b0) return;       // glitch, not a start bit
    d = '0;
    for (int k = 0; k < n; k++) begin  // lsb first
      repeat (BITC) @(posedge i_clk);
      d[k] = i_line;
    end
    repeat (BITC) @(posedge i_clk);
    stp = i_line;
  endtask : recv
endmodule : asf_remote_node

// ---- asf_core_bench.sv ----
// self-checking bench for the async serial frame core
module asf_core_bench;
  import asf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BITC = 32;            // 16 samples of div 1 plus one
  logic        i_clk;                  // system clock
  logic        i_rst_b;                // reset, active low
  logic [3:0]  i_addr;                 // register index
  logic [15:0] i_wdata;                // write data
  logic        i_wr;                   // write strobe
  logic        i_rd;                   // read strobe
  logic [15:0] o_rdata;                // read data
  logic        rx_line;                // node to core
  logic        o_serial_out_pin;       // core to node
  logic        o_serial_out_oe;        // transmit pin driven
  logic        o_rx_pin_owned;         // receive pin used
  logic        o_irq;                  // interrupt
  int          fail_count = 0;         // mismatches
  int          n_compared = 0;         // comparisons
  //////////////////////////////////////////////////////////////////////
  initial i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;         // 40 MHz
  asf_core #(.OVS(16)) asf_core_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_in_pin(rx_line), .o_serial_out_pin(o_serial_out_pin),
    .o_serial_out_oe(o_serial_out_oe), .o_rx_pin_owned(o_rx_pin_owned),
    .o_irq(o_irq));
  asf_remote_node #(.BITC(BITC)) asf_remote_node_i (
    .i_clk(i_clk), .i_line(o_serial_out_pin), .o_line(rx_line));
  //////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bus cycles: one strobe cycle, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic low_run(output int n);  // cycles the pin stays low
    int t;
    n = 0;
    t = 0;
    while (o_serial_out_pin !== 1'b0 && t < 4000) begin
      @(posedge i_clk); t++;
    end
    while (o_serial_out_pin === 1'b0 && n < 1000) begin
      @(posedge i_clk); n++;
    end
  endtask : low_run
  // send a character and judge the frame that appears on the pin
  task automatic tx_frame(input int n, input logic [8:0] d, input int lo);
    logic [8:0] got;
    logic       stp;
    int         len;
    wr(ASF_REG_TXDATA, {8'h00, d[7:0]});
    fork
      asf_remote_node_i.recv(n, got, stp);
      low_run(len);
    join
    chk("tx data", {7'h00, got}, {7'h00, d});
    chk("tx stop", {15'h0, stp}, 16'h0001);
    chk("start len", len[15:0], lo[15:0]);
    repeat (BITC) @(posedge i_clk);
    chk("idle", {15'h0, o_serial_out_pin}, 16'h0001);
  endtask : tx_frame
  task automatic rx_char(input int n, input logic [8:0] d, input logic s);
    @(posedge i_clk);
    asf_remote_node_i.send(n, d, s);
    repeat (8) @(posedge i_clk);       // synchroniser and store latency
  endtask : rx_char
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;              // reset values, unmapped place
    logic [15:0] v;
    chk("pins", {13'h0, o_serial_out_oe, o_rx_pin_owned, o_irq},
        16'h0000);
    rd(ASF_REG_BAUD, v);
    chk("baud", v, 16'h0015);
    rd(4'h8, v);
    chk("unmapped", v, 16'h0000);
  endtask : t_reset
  task automatic t_tx8;                // eight-bit frame, pin ownership
    logic [15:0] v;
    wr(ASF_REG_BAUD, 16'h0001);
    wr(ASF_REG_CTRL, 16'h0013);        // tx, rx, sixteen-bit divider
    @(posedge i_clk);
    chk("own", {14'h0, o_serial_out_oe, o_rx_pin_owned}, 16'h0003);
    tx_frame(8, 9'h0A5, BITC);
    rd(ASF_REG_STAT, v);
    chk("stat idle", v, 16'h0004);
  endtask : t_tx8
  task automatic t_duplex;             // both ways at once, interrupt
    logic [15:0] v;
    fork
      tx_frame(8, 9'h05A, 2 * BITC);
      rx_char(8, 9'h03C, 1'b1);
    join
    rd(ASF_REG_RXDATA, v);
    chk("duplex rx", v, 16'h003C);
    wr(ASF_REG_IRQEN, 16'h0002);
    rd(ASF_REG_IRQ, v);
    chk("irq flag", {15'h0, o_irq}, 16'h0001);
    chk("rx ready", v & 16'h0002, 16'h0002);
    wr(ASF_REG_IRQEN, 16'h0000);
    @(posedge i_clk);
    chk("masked", {15'h0, o_irq}, 16'h0000);
    wr(ASF_REG_IRQEN, 16'h0002);
    wr(ASF_REG_IRQCLR, 16'h000F);
    rd(ASF_REG_IRQ, v);
    chk("cleared", v, 16'h0000);
    chk("irq low", {15'h0, o_irq}, 16'h0000);
  endtask : t_duplex
  task automatic t_nine;               // ninth bit out and in, addresses
    logic [15:0] v;
    wr(ASF_REG_CTRL, 16'h0057);        // nine bits, ninth bit one
    tx_frame(9, 9'h133, BITC);
    rx_char(9, 9'h1C3, 1'b1);
    rd(ASF_REG_RXDATA, v);
    chk("rx nine", v, 16'h01C3);
    wr(ASF_REG_CTRL, 16'h001F);        // address detection on
    rx_char(9, 9'h044, 1'b1);
    rd(ASF_REG_STAT, v);
    chk("data dropped", v & 16'h0008, 16'h0000);
    rx_char(9, 9'h145, 1'b1);
    rd(ASF_REG_RXDATA, v);
    chk("address", v, 16'h0145);
  endtask : t_nine
  task automatic t_errors;             // overrun, then bad stop bit
    logic [15:0] v;
    wr(ASF_REG_CTRL, 16'h0013);
    wr(ASF_REG_IRQCLR, 16'h000F);
    rx_char(8, 9'h011, 1'b1);
    rx_char(8, 9'h022, 1'b1);
    rd(ASF_REG_IRQ, v);
    chk("overrun", v & 16'h0004, 16'h0004);
    rd(ASF_REG_RXDATA, v);
    chk("kept", v, 16'h0011);
    rx_char(8, 9'h033, 1'b0);
    rd(ASF_REG_STAT, v);
    chk("ferr stat", v & 16'h0010, 16'h0010);
    rd(ASF_REG_IRQ, v);
    chk("ferr irq", v & 16'h0008, 16'h0008);
    rd(ASF_REG_RXDATA, v);
    chk("ferr data", v, 16'h0033);
  endtask : t_errors
  task automatic t_break;              // long break, then idle
    int len;
    wr(ASF_REG_CTRL, 16'h0033);
    low_run(len);
    chk("break", len[15:0], 16'(ASF_BREAK_BITS * BITC));
    repeat (2 * BITC) @(posedge i_clk);
    chk("after", {15'h0, o_serial_out_pin}, 16'h0001);
  endtask : t_break
  task automatic t_brg8;               // 8-bit divider ignores high byte
    int len;
    wr(ASF_REG_CTRL, 16'h0003);
    wr(ASF_REG_BAUD, 16'h0100);
    wr(ASF_REG_TXDATA, 16'h0001);
    low_run(len);
    chk("brg8", len[15:0], 16'h0010);
    repeat (200) @(posedge i_clk);
    wr(ASF_REG_CTRL, 16'h0000);
    @(posedge i_clk);
    chk("released", {14'h0, o_serial_out_oe, o_rx_pin_owned}, 16'h0000);
  endtask : t_brg8
  //////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_b = 1'b0; i_addr = '0; i_wdata = '0; i_wr = 1'b0; i_rd = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_tx8();
    t_duplex();
    t_nine();
    t_errors();
    t_break();
    t_brg8();
    final_report();
  end
endmodule : asf_core_bench
